// ### sim/host_cpu_model.sv
// host cpu model: strobes change after an edge; a released bus drifts
module host_cpu_model (input wire c_i, oe_i, input wire [7:0] d_i,
    output reg cs_n_o = 1'b1, rd_n_o = 1'b1, output wire [7:0] bus_o);
    timeunit 1ns; timeprecision 1ns;
    reg [7:0] last_r = 8'h00;
    assign bus_o = oe_i ? d_i : ~last_r;
    always @(posedge c_i) last_r <= bus_o;
    task strobe(input cs, rd); @(posedge c_i); #10 {cs_n_o, rd_n_o} = {cs, rd}; endtask
endmodule // host_cpu_model

// ### sim/pin_mux_props.sv
// checker on pin_mux_top ports; assumes outputs one cycle behind inputs
module pin_mux_props (
    input wire       core_clk_i, nrst_i, general_output_1_sel_i, cs_n_i, rd_n_i, z_mode_i,
    input wire       interrupt_acknowledge_cycle_i, int_pending_i, data_oe_o,
    input wire       interrupt_request_n_oe_o, chan_b_request_to_send_n_i,
    input wire [7:0] gpo_value_i, read_data_i, data_o, general_output_pins_o);
    timeunit 1ns; timeprecision 1ns;
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!nrst_i);
    property p_rts;
        general_output_1_sel_i |=> general_output_pins_o[1] == $past(chan_b_request_to_send_n_i);
    endproperty
    a_rts: assert property (p_rts) else $error("rts level");
    property p_gpo;
        !general_output_1_sel_i |=> general_output_pins_o[1] == $past(gpo_value_i[1]);
    endproperty
    a_gpo: assert property (p_gpo) else $error("gpo level");
    property p_off;
        cs_n_i && !(z_mode_i && interrupt_acknowledge_cycle_i) |=> !data_oe_o;
    endproperty
    a_off: assert property (p_off) else $error("bus on");
    property p_rdh;
        rd_n_i && !(z_mode_i && interrupt_acknowledge_cycle_i) |=> !data_oe_o;
    endproperty
    a_rdh: assert property (p_rdh) else $error("bus on");
    property p_rd;
        !cs_n_i && !rd_n_i |=> data_oe_o;
    endproperty
    a_rd: assert property (p_rd) else $error("bus off");
    property p_dat;
        !cs_n_i && !rd_n_i && !(z_mode_i && interrupt_acknowledge_cycle_i) |=>
            data_o == $past(read_data_i);
    endproperty
    a_dat: assert property (p_dat) else $error("bus data");
    property p_irq;
        int_pending_i |=> interrupt_request_n_oe_o;
    endproperty
    a_irq: assert property (p_irq) else $error("irq");
    property p_clr;
        !int_pending_i |=> !interrupt_request_n_oe_o;
    endproperty
    a_clr: assert property (p_clr) else $error("irq held");
endmodule // pin_mux_props
bind pin_mux_top pin_mux_props i_pin_mux_props (.*);

// ### sim/pin_mux_top_tb_top.sv
// bench for pin_mux_top; assumes host_cpu_model drives the strobes
module pin_mux_top_tb_top;
    timeunit 1ns; timeprecision 1ns;
    reg core_clk_i = 1'b0, nrst_i = 1'b0, z_mode_i = 1'b0, int_pending_i = 1'b0;
    reg interrupt_acknowledge_cycle_i = 1'b0;
    reg [6:0] s = 7'h00;
    reg [7:0] a = 8'h00, gpo_value_i = 8'h00, read_data_i = 8'h1E;
    wire [7:0] general_output_pins_o, general_output_pins_oe_o, data_i, data_o, write_data_o;
    wire cs_n_i, rd_n_i, data_oe_o, interrupt_request_n_oe_o, interrupt_request_n_o;
    integer mismatches = 0, n_compared = 0;
    pin_mux_top i_pin_mux_top (.*, .general_output_1_sel_i(s[0]),
        .general_output_3_sel_i(s[2:1]), .general_output_5_sel_i(s[3]),
        .general_output_5_full_i(s[4]), .general_output_6_sel_i(s[5]),
        .general_output_7_sel_i(s[6]), .ct_ready_n_i(a[3]),
        .chan_b_request_to_send_n_i(a[0]), .chan_b_tx_clock_1x_out_i(a[1]),
        .chan_b_rx_clock_1x_out_i(a[2]), .chan_b_receiver_ready_n_i(a[4]),
        .chan_b_rx_fifo_full_n_i(a[5]), .chan_a_transmitter_ready_n_i(a[6]),
        .chan_b_transmitter_ready_n_i(a[7]), .ack_cycle_data_i(8'h6C));
    host_cpu_model i_host_cpu_model (.c_i(core_clk_i), .oe_i(data_oe_o), .d_i(data_o),
        .cs_n_o(cs_n_i), .rd_n_o(rd_n_i), .bus_o(data_i));
    task step; @(posedge core_clk_i); #10; endtask
    task chk(input [7:0] got, exp); n_compared++;
        if (got !== exp) begin mismatches++; $display("Error %0t got %h", $time, got); end endtask
    task pins(input [6:0] v, input [7:0] w, g); s = v; a = w; gpo_value_i = g; step; endtask
    task complete_run; if (mismatches == 0 && n_compared > 0)
        $display("SIMULATION PASSED");
    else
        $display("SIMULATION FAILED");
    $finish; endtask
    task t_alt; pins(7'h7F, 8'h00, 8'hFF); chk(general_output_pins_o, 8'h15);
        pins(7'h6F, 8'hEF, 8'h00); chk(general_output_pins_oe_o, 8'h37);
        pins(7'h03, 8'h02, 8'hA5); chk(general_output_pins_o, 8'hAD);
        pins(7'h05, 8'h04, 8'h00); chk(general_output_pins_o, 8'h08);
        chk(general_output_pins_oe_o, 8'hFF); endtask
    task t_rst; nrst_i = 1'b0; step;
        chk(general_output_pins_o, 8'hFF);
        nrst_i = 1'b1; step;
        chk(general_output_pins_o, 8'h08); endtask
    task t_bus; i_host_cpu_model.strobe(1'b0, 1'b0); step; chk(data_i, 8'h1E);
        i_host_cpu_model.strobe(1'b1, 1'b0); step; chk(data_oe_o, 8'h00);
        i_host_cpu_model.strobe(1'b0, 1'b1); step; chk(data_oe_o, 8'h00);
        i_host_cpu_model.strobe(1'b1, 1'b1); z_mode_i = 1'b1; step;
        chk(data_oe_o, 8'h00);
        interrupt_acknowledge_cycle_i = 1'b1; step; chk(data_i, 8'h6C);
        step; chk(write_data_o, 8'h6C); endtask
    task t_irq; int_pending_i = 1'b1; step; chk(interrupt_request_n_oe_o, 8'h01);
        chk(interrupt_request_n_o, 8'h00);
        step; chk(interrupt_request_n_oe_o, 8'h01);
        int_pending_i = 1'b0; step; chk(interrupt_request_n_oe_o, 8'h00);
        chk(interrupt_request_n_o, 8'h01); endtask
    initial forever #50 core_clk_i = ~core_clk_i;
    initial begin step; step; chk(general_output_pins_o & general_output_pins_oe_o, 8'hFF);
        nrst_i = 1'b1; t_alt; t_rst; t_bus; t_irq; complete_run; end
    initial begin #20000; mismatches++; complete_run; end
endmodule // pin_mux_top_tb_top

// ### verilog/out_pin_cell.v
// one output port pin: general value or alternate function, registered
// assumes the select and alternate levels are synchronous to core_clk_i
`include "pin_mux_regs.vh"
module out_pin_cell (
    // clock and reset
    input  wire       core_clk_i,
    input  wire       nrst_i,
    // function selection
    input  wire [1:0] sel_i,
    input  wire       gpo_i,
    input  wire       alt1_i,
    input  wire       alt2_i,
    input  wire       alt3_i,
    input  wire       od_i,
    // pin
    output reg        pin_o,
    output reg        pin_oe_o
);
    reg lvl_nxt;
    reg od_sel_nxt;
    always @* begin
        lvl_nxt    = gpo_i;
        od_sel_nxt = 1'b0;
        case (sel_i)
            `SEL_GPO:  lvl_nxt = gpo_i;
            `SEL_ALT1: lvl_nxt = alt1_i;
            `SEL_ALT2: lvl_nxt = alt2_i;
            `SEL_ALT3: begin
                lvl_nxt    = alt3_i;
                od_sel_nxt = od_i;
            end
            default:   lvl_nxt = gpo_i;
        endcase
    end
    // master reset drives pin high
    // open drain only pulls low; high level is released
    always @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pin_o    <= 1'b1;
            pin_oe_o <= 1'b1;
        end else begin
            pin_o    <= lvl_nxt;
            pin_oe_o <= od_sel_nxt ? ~lvl_nxt : 1'b1;
        end
    end
endmodule // out_pin_cell

// ### verilog/pin_mux_regs.vh
// constants for the output port and host bus pin block
// included by pin_mux_top.v and out_pin_cell.v
`ifndef PIN_MUX_REGS_VH
`define PIN_MUX_REGS_VH
// output pin function selects
`define SEL_GPO        2'h0
`define SEL_ALT1       2'h1
`define SEL_ALT2       2'h2
`define SEL_ALT3       2'h3
// reset level of every general output pin
`define OUT_RESET_LVL  8'hFF
`define BUS_WIDTH      8
`endif

// ### verilog/pin_mux_top.v
// output port pin multiplexer and host data bus / interrupt pins
// assumes all inputs synchronous to core_clk_i; reset is the master reset
// Operation
// - pin 1 carries channel B RTS low
// - pin 3: tx/rx 1X clock or C/T ready
// - pin 5 open-drain receiver ready or full
// - pins 6,7 open-drain transmitter ready A/B
// - eight-bit data bus, bit 0 LSB
// - bus released while chip select high, except in a z-mode interrupt acknowledge cycle
// - interrupt pulled low on unmasked condition
// - interrupt holds until all conditions cleared
// - read with chip select drives register data, except in a z-mode interrupt acknowledge cycle
// - reset forces port pins and interrupt level high; bus enable, bus data and write data low
`include "pin_mux_regs.vh"
module pin_mux_top #(
    parameter W = `BUS_WIDTH
) (
    // clock and reset
    input  wire         core_clk_i,
    input  wire         nrst_i,
    // general output value and selects
    input  wire [7:0]   gpo_value_i,
    input  wire         general_output_1_sel_i,
    input  wire [1:0]   general_output_3_sel_i,
    input  wire         general_output_5_sel_i,
    input  wire         general_output_5_full_i,
    input  wire         general_output_6_sel_i,
    input  wire         general_output_7_sel_i,
    // alternate function sources
    input  wire         chan_b_request_to_send_n_i,
    input  wire         chan_b_tx_clock_1x_out_i,
    input  wire         chan_b_rx_clock_1x_out_i,
    input  wire         ct_ready_n_i,
    input  wire         chan_b_receiver_ready_n_i,
    input  wire         chan_b_rx_fifo_full_n_i,
    input  wire         chan_a_transmitter_ready_n_i,
    input  wire         chan_b_transmitter_ready_n_i,
    // output port pins
    output wire [7:0]   general_output_pins_o,
    output wire [7:0]   general_output_pins_oe_o,
    // host bus
    input  wire         cs_n_i,
    input  wire         rd_n_i,
    input  wire         z_mode_i,
    input  wire         interrupt_acknowledge_cycle_i,
    input  wire [W-1:0] read_data_i,
    input  wire [W-1:0] ack_cycle_data_i,
    input  wire [W-1:0] data_i,
    output reg  [W-1:0] data_o,
    output reg          data_oe_o,
    output reg  [W-1:0] write_data_o,
    // interrupt
    input  wire         int_pending_i,
    output reg          interrupt_request_n_o,
    output reg          interrupt_request_n_oe_o
);
    // per-pin function select; pins 0, 2 and 4 have no alternate here
    wire [1:0] s1 = general_output_1_sel_i ? `SEL_ALT1 : `SEL_GPO;
    wire [1:0] s5 = general_output_5_sel_i ? `SEL_ALT3 : `SEL_GPO;
    wire [1:0] s6 = general_output_6_sel_i ? `SEL_ALT3 : `SEL_GPO;
    wire [1:0] s7 = general_output_7_sel_i ? `SEL_ALT3 : `SEL_GPO;
    wire       rx5 = general_output_5_full_i ? chan_b_rx_fifo_full_n_i
                                             : chan_b_receiver_ready_n_i;
    // reset high inside each cell; pins lag sources one clock

    out_pin_cell u_pin0 (
        .core_clk_i (core_clk_i),
        .nrst_i     (nrst_i),
        .sel_i      (`SEL_GPO),
        .gpo_i      (gpo_value_i[0]),
        .alt1_i     (1'b1),
        .alt2_i     (1'b1),
        .alt3_i     (1'b1),
        .od_i       (1'b0),
        .pin_o      (general_output_pins_o[0]),
        .pin_oe_o   (general_output_pins_oe_o[0])
    );

    out_pin_cell u_pin1 (
        .core_clk_i (core_clk_i),
        .nrst_i     (nrst_i),
        .sel_i      (s1),
        .gpo_i      (gpo_value_i[1]),
        .alt1_i     (chan_b_request_to_send_n_i),
        .alt2_i     (1'b1),
        .alt3_i     (1'b1),
        .od_i       (1'b0),
        .pin_o      (general_output_pins_o[1]),
        .pin_oe_o   (general_output_pins_oe_o[1])
    );

    out_pin_cell u_pin2 (
        .core_clk_i (core_clk_i),
        .nrst_i     (nrst_i),
        .sel_i      (`SEL_GPO),
        .gpo_i      (gpo_value_i[2]),
        .alt1_i     (1'b1),
        .alt2_i     (1'b1),
        .alt3_i     (1'b1),
        .od_i       (1'b0),
        .pin_o      (general_output_pins_o[2]),
        .pin_oe_o   (general_output_pins_oe_o[2])
    );

    // clocks or timer ready
    // clock modes push-pull; ready is open drain
    out_pin_cell u_pin3 (
        .core_clk_i (core_clk_i),
        .nrst_i     (nrst_i),
        .sel_i      (general_output_3_sel_i),
        .gpo_i      (gpo_value_i[3]),
        .alt1_i     (chan_b_tx_clock_1x_out_i),
        .alt2_i     (chan_b_rx_clock_1x_out_i),
        .alt3_i     (ct_ready_n_i),
        .od_i       (1'b1),
        .pin_o      (general_output_pins_o[3]),
        .pin_oe_o   (general_output_pins_oe_o[3])
    );

    out_pin_cell u_pin4 (
        .core_clk_i (core_clk_i),
        .nrst_i     (nrst_i),
        .sel_i      (`SEL_GPO),
        .gpo_i      (gpo_value_i[4]),
        .alt1_i     (1'b1),
        .alt2_i     (1'b1),
        .alt3_i     (1'b1),
        .od_i       (1'b0),
        .pin_o      (general_output_pins_o[4]),
        .pin_oe_o   (general_output_pins_oe_o[4])
    );

    out_pin_cell u_pin5 (
        .core_clk_i (core_clk_i),
        .nrst_i     (nrst_i),
        .sel_i      (s5),
        .gpo_i      (gpo_value_i[5]),
        .alt1_i     (1'b1),
        .alt2_i     (1'b1),
        .alt3_i     (rx5),
        .od_i       (1'b1),
        .pin_o      (general_output_pins_o[5]),
        .pin_oe_o   (general_output_pins_oe_o[5])
    );

    out_pin_cell u_pin6 (
        .core_clk_i (core_clk_i),
        .nrst_i     (nrst_i),
        .sel_i      (s6),
        .gpo_i      (gpo_value_i[6]),
        .alt1_i     (1'b1),
        .alt2_i     (1'b1),
        .alt3_i     (chan_a_transmitter_ready_n_i),
        .od_i       (1'b1),
        .pin_o      (general_output_pins_o[6]),
        .pin_oe_o   (general_output_pins_oe_o[6])
    );

    out_pin_cell u_pin7 (
        .core_clk_i (core_clk_i),
        .nrst_i     (nrst_i),
        .sel_i      (s7),
        .gpo_i      (gpo_value_i[7]),
        .alt1_i     (1'b1),
        .alt2_i     (1'b1),
        .alt3_i     (chan_b_transmitter_ready_n_i),
        .od_i       (1'b1),
        .pin_o      (general_output_pins_o[7]),
        .pin_oe_o   (general_output_pins_oe_o[7])
    );

    // exception only in second bus mode
    wire ack_cycle = z_mode_i & interrupt_acknowledge_cycle_i;

    // bit 0 LSB, eight wide
    // captured every clock; write strobe decoded elsewhere
    always @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            write_data_o <= {W{1'b0}};
        end else begin
            write_data_o <= data_i;
        end
    end

    // read drives register data
    // vector wins over register data; chip select ignored then
    always @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            data_oe_o <= 1'b0;
            data_o    <= {W{1'b0}};
        end else begin
            data_oe_o <= (~cs_n_i & ~rd_n_i) | ack_cycle;
            data_o    <= ack_cycle ? ack_cycle_data_i : read_data_i;
        end
    end

    // held while any condition stands
    // level low while pulling, so the pull-up sees no fight
    always @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            interrupt_request_n_o    <= 1'b1;
            interrupt_request_n_oe_o <= 1'b0;
        end else begin
            interrupt_request_n_o    <= ~int_pending_i;
            interrupt_request_n_oe_o <= int_pending_i;
        end
    end
endmodule // pin_mux_top
